//--- rocof_pkg.sv
// Shared constants, register map and carrier types of the df/dt element.
package rocof_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 50;
    localparam longint CLK_HZ = 64'd1000000000 / CLK_PERIOD_NS;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] THRESH_OFS = 8'h04;
    localparam logic [7:0] DELAY_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] INT_STAT_OFS = 8'h10;
    localparam logic [7:0] INT_MASK_OFS = 8'h14;
    localparam logic [7:0] FREQ_OFS = 8'h18;

    // Control field positions.
    localparam int CTRL_OPERATE_BIT = 0;
    localparam int CTRL_START_ONLY_BIT = 1;

    // Status field positions.
    localparam int ST_START_BIT = 0;
    localparam int ST_TRIP_BIT = 1;
    localparam int ST_CMP_BIT = 2;
    localparam int ST_FREQ_OK_BIT = 3;
    localparam int ST_VOLT_OK_BIT = 4;

    // Interrupt status and mask field positions.
    localparam int EV_START_ON_BIT = 0;
    localparam int EV_START_OFF_BIT = 1;
    localparam int EV_TRIP_ON_BIT = 2;
    localparam int EV_TRIP_OFF_BIT = 3;
    localparam int EV_BITS = 4;

    // Setting widths, ranges and reset values.
    localparam int THR_W = 11;
    localparam int DELAY_W = 14;
    localparam logic signed [THR_W-1:0] THR_MIN = -11'sd500;
    localparam logic signed [THR_W-1:0] THR_MAX = 11'sd500;
    localparam logic signed [THR_W-1:0] THR_RESET = 11'sd50;
    localparam logic [DELAY_W-1:0] DELAY_MIN_MS = 14'd200;
    localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 14'd10000;
    localparam logic [DELAY_W-1:0] DELAY_RESET_MS = 14'd200;
    localparam logic OPERATE_RESET = 1'b0;
    localparam logic START_ONLY_RESET = 1'b0;
    localparam logic [EV_BITS-1:0] INT_MASK_RESET = 4'h0;

    // Comparator filter time and drop-off ratios in thousandths.
    localparam logic [DELAY_W-1:0] FILTER_MS = 14'd100;
    localparam logic [9:0] RATIO_PICK = 10'd1000;
    localparam logic [9:0] RATIO_HIGH = 10'd920;
    localparam logic [9:0] RATIO_LOW = 10'd999;
    localparam logic [THR_W-1:0] RATIO_KNEE = 11'd50;
    localparam longint SLOPE_SCALE = CLK_HZ * 100;

    // Measurement history and qualification.
    localparam int HIST_DEPTH = 5;
    localparam logic [2:0] QUAL_COUNT = 3'd4;
    localparam int FREQ_W = 17;
    localparam int VOLT_W = 16;
    localparam logic [VOLT_W-1:0] UN_CODE = 16'h4000;
    localparam logic [VOLT_W-1:0] VOLT_MIN = (UN_CODE + 16'h0009) / 16'h000a;

    // One frequency measurement from the zero-crossing front end.
    typedef struct packed {
        logic strobe;
        logic valid;
        logic [FREQ_W-1:0] freq;
        logic [VOLT_W-1:0] volt;
    } meas_t;

    // Qualified frequency handed to the slope logic.
    typedef struct packed {
        logic strobe;
        logic ok;
        logic [FREQ_W-1:0] freq;
    } acc_t;

    // Change events of the general start and trip outputs.
    typedef struct packed {
        logic start_evt;
        logic start_val;
        logic trip_evt;
        logic trip_val;
    } event_t;

endpackage : rocof_pkg

//--- freq_qualifier.sv
// Frequency acceptance filter: consecutive valid and invalid counting.
`timescale 1ns/100ps
module freq_qualifier (
    input wire logic pclk,
    input wire logic presetn,
    input wire rocof_pkg::meas_t meas,
    output rocof_pkg::acc_t acc
);
    import rocof_pkg::*;

    typedef struct packed {
        logic [2:0] good_cnt;
        logic [2:0] bad_cnt;
        acc_t acc;
    } qual_state_t;

    qual_state_t state;
    qual_state_t next_state;

    // A lone good or bad reading never changes the accepted value.
    always_comb begin
        next_state = state;
        next_state.acc.strobe = 1'b0;
        if (meas.strobe) begin
            next_state.acc.strobe = 1'b1;
            if (meas.valid) begin
                next_state.bad_cnt = 3'd0;
                if (state.good_cnt < QUAL_COUNT) begin
                    next_state.good_cnt = state.good_cnt + 3'd1;
                end
                if (next_state.good_cnt >= QUAL_COUNT) begin // RL15
                    next_state.acc.ok = 1'b1;
                    next_state.acc.freq = meas.freq;
                end
            end else begin
                next_state.good_cnt = 3'd0;
                if (state.bad_cnt < QUAL_COUNT) begin
                    next_state.bad_cnt = state.bad_cnt + 3'd1;
                end
                if (next_state.bad_cnt >= QUAL_COUNT) begin // RL15
                    next_state.acc.ok = 1'b0;
                    next_state.acc.freq = '0;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign acc = state.acc;

endmodule : freq_qualifier

//--- rocof_protection_logic.sv
// Rate-of-change-of-frequency protection element with APB settings.
`timescale 1ns/100ps

// Function
// RL1: Operate setting, off by default; off keeps start and trip low.
// RL2: Start-only setting, default false; when true trip never asserts.
// RL3: Signed threshold -5.00..5.00 Hz/s in 0.01 steps, default 0.50.
// RL4: Trip delay 200..10000 ms in 1 ms steps, default 200 ms.
// RL5: Delay runs from first fault appearance, not from start.
// RL6: Outside logic drives one blocking input that drops start and trip.
// RL7: Start asserts while slope passes threshold, enabled and unblocked.
// RL8: Trip asserts after fault persists for delay, unless start-only.
// RL9: Each start or trip change emits an on or off event.
// RL10: No operation below one tenth of rated voltage.
// RL11: Drop-off at 0.92 of setting above 0.5 Hz/s, else 0.999.
// RL12: Voltage source chosen by configuration, not at run time.
// RL13: Slope is present frequency minus frequency five periods earlier.
// RL14: Comparator result must hold 100 ms before start may rise.
// RL15: Frequency accepted after four valid readings, zeroed after four bad.
// RL16: Positive threshold picks up above it, negative below it.
// RL17: Reset clears timer and deasserts start and trip.
module rocof_protection_logic #(
    parameter bit USE_LINE_VOLT = 1'b0,
    parameter int TICK_LEN = rocof_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rocof_pkg::meas_t meas_phase,
    input wire rocof_pkg::meas_t meas_line,
    input wire logic block_in,
    output logic general_start_out,
    output logic general_trip_out,
    output rocof_pkg::event_t events,
    output logic irq
);
    import rocof_pkg::*;

    typedef struct packed {
        logic operate;
        logic start_only;
        logic signed [THR_W-1:0] thr;
        logic [DELAY_W-1:0] delay;
        logic [EV_BITS-1:0] int_stat;
        logic [EV_BITS-1:0] int_mask;
        logic [31:0] prdata;
        logic [HIST_DEPTH-1:0][FREQ_W-1:0] hist_freq;
        logic [HIST_DEPTH-1:0][31:0] hist_ts;
        logic [2:0] hist_cnt;
        logic [31:0] ts;
        logic cmp_flag;
        logic [23:0] tick_cnt;
        logic [DELAY_W-1:0] fault_ms;
        logic start;
        logic trip;
        event_t evt;
    } main_state_t;

    main_state_t state;
    main_state_t next_state;
    meas_t meas_sel;
    acc_t acc;
    logic volt_ok;
    logic fault;
    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [31:0] rd_word;
    logic signed [THR_W-1:0] wr_thr;
    logic [DELAY_W-1:0] wr_delay;
    logic [9:0] ratio;
    logic [THR_W-1:0] thr_abs;
    logic signed [63:0] df;
    logic signed [63:0] dt;
    logic signed [63:0] lhs;
    logic signed [63:0] rhs;
    logic pass;
    logic [EV_BITS-1:0] ev_set;
    logic [23:0] tick_last;

    // The source is a build-time choice so no mux glitch can ever
    // disturb the frequency history while the element runs.
    assign meas_sel = USE_LINE_VOLT ? meas_line : meas_phase; // RL12

    freq_qualifier u_qual (
        .pclk(pclk),
        .presetn(presetn),
        .meas(meas_sel),
        .acc(acc)
    );

    // Voltage supervision against the rated level.
    assign volt_ok = (meas_sel.volt >= VOLT_MIN); // RL10

    // The bus answers at once, so only a bad address raises an error.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    always_comb begin
        case (paddr)
            CTRL_OFS, THRESH_OFS, DELAY_OFS, STATUS_OFS,
            INT_STAT_OFS, INT_MASK_OFS, FREQ_OFS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_hit;

    // Out-of-range settings are clamped rather than refused, so the
    // element always holds a legal value after any write.
    always_comb begin
        wr_thr = pwdata[THR_W-1:0];
        if ($signed(pwdata) < $signed(32'(THR_MIN))) begin // RL3
            wr_thr = THR_MIN;
        end else if ($signed(pwdata) > $signed(32'(THR_MAX))) begin // RL3
            wr_thr = THR_MAX;
        end
        wr_delay = pwdata[DELAY_W-1:0];
        if (pwdata < 32'(DELAY_MIN_MS)) begin // RL4
            wr_delay = DELAY_MIN_MS;
        end else if (pwdata > 32'(DELAY_MAX_MS)) begin // RL4
            wr_delay = DELAY_MAX_MS;
        end
    end

    // Read multiplexer; the word is captured in the setup phase.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            CTRL_OFS: begin
                rd_word[CTRL_OPERATE_BIT] = state.operate;
                rd_word[CTRL_START_ONLY_BIT] = state.start_only;
            end
            THRESH_OFS: rd_word = 32'(state.thr);
            DELAY_OFS: rd_word = 32'(state.delay);
            STATUS_OFS: begin
                rd_word[ST_START_BIT] = state.start;
                rd_word[ST_TRIP_BIT] = state.trip;
                rd_word[ST_CMP_BIT] = state.cmp_flag;
                rd_word[ST_FREQ_OK_BIT] = acc.ok;
                rd_word[ST_VOLT_OK_BIT] = volt_ok;
            end
            INT_STAT_OFS: rd_word = 32'(state.int_stat);
            INT_MASK_OFS: rd_word = 32'(state.int_mask);
            FREQ_OFS: rd_word = 32'(acc.freq);
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Slope comparison without division: df * f_clk * 100 is set against
    // threshold * ratio * elapsed cycles over the same five periods.
    always_comb begin
        thr_abs = state.thr[THR_W-1] ? 11'(-state.thr) : 11'(state.thr);
        if (!state.cmp_flag) begin
            ratio = RATIO_PICK;
        end else if (thr_abs > RATIO_KNEE) begin // RL11
            ratio = RATIO_HIGH;
        end else begin
            ratio = RATIO_LOW; // RL11
        end
        df = $signed({47'd0, acc.freq})
            - $signed({47'd0, state.hist_freq[HIST_DEPTH-1]}); // RL13
        dt = $signed({32'd0, state.ts - state.hist_ts[HIST_DEPTH-1]});
        lhs = df * SLOPE_SCALE;
        rhs = 64'(state.thr) * $signed({54'd0, ratio}) * dt;
        if (state.thr[THR_W-1]) begin
            pass = lhs < rhs; // RL16
        end else begin
            pass = lhs > rhs; // RL16
        end
    end

    // The fault condition that starts the delay timer.
    assign fault = state.operate && !block_in && volt_ok && acc.ok
        && state.cmp_flag; // RL1 RL6 RL10
    assign tick_last = 24'(TICK_LEN - 1);

    // Next-state logic for settings, history, timer and outputs.
    always_comb begin
        next_state = state;
        next_state.ts = state.ts + 32'd1;

        // Register writes.
        if (wr_en) begin
            case (paddr)
                CTRL_OFS: begin
                    next_state.operate = pwdata[CTRL_OPERATE_BIT]; // RL1
                    next_state.start_only = pwdata[CTRL_START_ONLY_BIT];
                end
                THRESH_OFS: next_state.thr = wr_thr; // RL3
                DELAY_OFS: next_state.delay = wr_delay; // RL4
                INT_MASK_OFS: next_state.int_mask = pwdata[EV_BITS-1:0];
                default: next_state.operate = state.operate;
            endcase
        end
        if (rd_setup) begin
            next_state.prdata = rd_word;
        end

        // Frequency history, shifted at every accepted reading with voltage present, restarted otherwise.
        if (acc.strobe) begin
            if (!acc.ok || !volt_ok) begin
                next_state.hist_cnt = 3'd0;
                next_state.cmp_flag = 1'b0; // RL10
            end else begin
                if (state.hist_cnt == 3'(HIST_DEPTH)) begin
                    next_state.cmp_flag = pass; // RL13
                end else begin
                    next_state.hist_cnt = state.hist_cnt + 3'd1;
                end
                for (int i = HIST_DEPTH - 1; i > 0; i--) begin
                    next_state.hist_freq[i] = state.hist_freq[i-1];
                    next_state.hist_ts[i] = state.hist_ts[i-1];
                end
                next_state.hist_freq[0] = acc.freq;
                next_state.hist_ts[0] = state.ts;
            end
        end

        // Millisecond timer restarts on each fresh fault, so delay and
        // filter both count from the moment the fault appears.
        if (!fault) begin
            next_state.tick_cnt = 24'd0;
            next_state.fault_ms = '0; // RL5
        end else if (state.tick_cnt >= tick_last) begin
            next_state.tick_cnt = 24'd0;
            if (state.fault_ms != {DELAY_W{1'b1}}) begin
                next_state.fault_ms = state.fault_ms + 14'd1; // RL5
            end
        end else begin
            next_state.tick_cnt = state.tick_cnt + 24'd1;
        end

        // Start after the comparator filter, trip after the set delay.
        next_state.start = fault && (state.fault_ms >= FILTER_MS); // RL7 RL14
        next_state.trip = fault && !state.start_only
            && (state.fault_ms >= state.delay); // RL2 RL8

        // Change events, one-cycle pulses carrying the new value.
        next_state.evt.start_evt = next_state.start != state.start; // RL9
        next_state.evt.start_val = next_state.start;
        next_state.evt.trip_evt = next_state.trip != state.trip; // RL9
        next_state.evt.trip_val = next_state.trip;

        // Sticky event bits, taken inside this process to avoid a loop.
        ev_set = '0;
        ev_set[EV_START_ON_BIT] = next_state.start && !state.start;
        ev_set[EV_START_OFF_BIT] = !next_state.start && state.start;
        ev_set[EV_TRIP_ON_BIT] = next_state.trip && !state.trip;
        ev_set[EV_TRIP_OFF_BIT] = !next_state.trip && state.trip;

        // Write-one-to-clear, but a new event wins over the clear.
        if (wr_en && paddr == INT_STAT_OFS) begin
            next_state.int_stat = state.int_stat & ~pwdata[EV_BITS-1:0];
        end
        next_state.int_stat = next_state.int_stat | ev_set;
    end

    // State register; all settings return to their defaults.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0; // RL17
            state.operate <= OPERATE_RESET;
            state.start_only <= START_ONLY_RESET;
            state.thr <= THR_RESET;
            state.delay <= DELAY_RESET_MS;
            state.int_mask <= INT_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register.
    assign prdata = state.prdata;
    assign general_start_out = state.start;
    assign general_trip_out = state.trip;
    assign events = state.evt;
    assign irq = |(state.int_stat & state.int_mask);

endmodule : rocof_protection_logic

//--- rocof_assertions.sv
// Port-level assertions for the df/dt protection element.
`timescale 1ns/100ps
module rocof_assertions #(
    parameter int TICK_LEN = rocof_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire rocof_pkg::meas_t meas_phase,
    input wire rocof_pkg::meas_t meas_line,
    input wire logic block_in,
    input wire logic general_start_out,
    input wire logic general_trip_out,
    input wire rocof_pkg::event_t events,
    input wire logic irq
);
    import rocof_pkg::*;
    // Two cycles of slack allow for the registered fault and output stages.
    localparam int HOLD = 100 * TICK_LEN - 2;
    logic [31:0] free_cnt;
    logic [31:0] start_cnt;

    // Saturating counts of unblocked cycles and of cycles with start high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_cnt <= 32'h0;
            start_cnt <= 32'h0;
        end else begin
            free_cnt <= block_in ? 32'h0 : free_cnt + 32'(~&free_cnt);
            start_cnt <= general_start_out ?
                start_cnt + 32'(~&start_cnt) : 32'h0;
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence access_phase;
        psel && penable;
    endsequence
    sequence aligned_access;
        access_phase ##0 paddr[1:0] == 2'b00;
    endsequence

    a_pready_access: assert property (access_phase |-> pready)
        else $error("pready low in an access phase");
    a_slverr_map: assert property (
        aligned_access |-> pslverr == (paddr > FREQ_OFS))
        else $error("pslverr does not follow the address map");
    a_reset_clears: assert property (
        $rose(presetn) |-> !general_start_out && !general_trip_out)
        else $error("output high just after reset");
    a_block_drops: assert property (
        block_in |=> !general_start_out && !general_trip_out)
        else $error("output high one cycle after blocking");
    a_start_event: assert property (
        events.start_evt == $changed(general_start_out))
        else $error("start event does not match a start change");
    a_start_value: assert property (
        events.start_evt |-> events.start_val == general_start_out)
        else $error("start event carries the wrong value");
    a_trip_event: assert property (
        $changed(general_trip_out) |->
        events.trip_evt && events.trip_val == general_trip_out)
        else $error("trip change without a matching event");
    a_trip_with_start: assert property (
        general_trip_out |-> general_start_out)
        else $error("trip high while start is low");
    a_start_filter: assert property (
        $rose(general_start_out) |-> free_cnt >= HOLD)
        else $error("start rose before the filter time");
    a_trip_delay: assert property (
        $rose(general_trip_out) |-> start_cnt >= HOLD)
        else $error("trip rose too soon after start");
endmodule : rocof_assertions

bind rocof_protection_logic rocof_assertions #(.TICK_LEN(TICK_LEN)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_phase(meas_phase),
    .meas_line(meas_line), .block_in(block_in),
    .general_start_out(general_start_out),
    .general_trip_out(general_trip_out), .events(events), .irq(irq)
);

//--- meas_source.sv
// Zero-crossing measurement source that feeds the element.
`timescale 1ns/100ps
module meas_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] period,
    input wire logic signed [7:0] step,
    input wire logic valid,
    input wire logic [15:0] volt,
    output rocof_pkg::meas_t meas
);
    import rocof_pkg::*;
    typedef struct packed {
        logic [15:0] cnt;
        logic [FREQ_W-1:0] freq;
    } src_t;
    src_t st;
    src_t next_st;
    logic fire;

    // One reading per period; the frequency ramps by step each time.
    always_comb begin
        fire = (st.cnt == period - 16'h0001);
        next_st = st;
        next_st.cnt = fire ? 16'h0000 : st.cnt + 16'h0001;
        if (fire) begin
            next_st.freq = st.freq + FREQ_W'(step);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{cnt: 16'h0000, freq: 17'h0c350};
        end else begin
            st <= next_st;
        end
    end

    // Between readings the valid and frequency lines carry the inverse, so stale use shows.
    assign meas = '{strobe: fire, valid: fire ? valid : ~valid,
                    freq: fire ? st.freq : ~st.freq, volt: volt};
endmodule : meas_source

//--- rocof_protection_logic_bench.sv
// Self-checking bench for the df/dt protection element.
`timescale 1ns/100ps
module rocof_protection_logic_bench;
    import rocof_pkg::*;
    localparam int TL = 4;
    localparam int PER = 200;
    localparam int T100 = 100 * TL;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic block_in = 1'b0;
    logic signed [7:0] step = 8'sh01;
    logic valid = 1'b1;
    logic [15:0] volt = UN_CODE;
    logic [31:0] prdata, rd, f0;
    logic pready, pslverr, err, general_start_out, general_trip_out, irq;
    event_t events;
    meas_t meas_phase, meas_line;
    int waited;
    int error_cnt = 0;
    int comparisons = 0;

    always #25 pclk = ~pclk;

    // The line source only sends invalid readings, so it must be ignored.
    meas_source src (.pclk(pclk), .presetn(presetn), .period(16'(PER)),
        .step(step), .valid(valid), .volt(volt), .meas(meas_phase));
    meas_source line_src (.pclk(pclk), .presetn(presetn), .period(16'h0033),
        .step(8'sh05), .valid(1'b0), .volt(16'h0000), .meas(meas_line));
    rocof_protection_logic #(.USE_LINE_VOLT(1'b0), .TICK_LEN(TL)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_phase(meas_phase),
        .meas_line(meas_line), .block_in(block_in),
        .general_start_out(general_start_out),
        .general_trip_out(general_trip_out), .events(events), .irq(irq));

    // Closing report and verdict.
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic give_up();
        error_cnt++;
        finish_test();
    endtask : give_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] b(input logic x);
        return {31'h0, x};
    endfunction : b

    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) give_up();
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp);
    endtask : rdchk

    // Flops are read at the edge, before that edge's updates land.
    task automatic wait_out(input bit trip, input logic lvl, input int lim);
        for (waited = 0; waited < lim; waited++) begin
            @(posedge pclk);
            if ((trip ? general_trip_out : general_start_out) === lvl) break;
        end
        if (waited == lim) give_up();
    endtask : wait_out

    task automatic sync(input int n);
        repeat (n) begin
            for (waited = 0; waited <= PER; waited++) begin
                @(posedge pclk);
                if (meas_phase.strobe === 1'b1) break;
            end
            if (waited > PER) give_up();
            repeat (4) @(posedge pclk);
        end
    endtask : sync

    function automatic logic [31:0] near(input int n, input int exp);
        return b(n >= exp - 5 * TL && n <= exp + 5 * TL);
    endfunction : near

    // Main sequence.
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(CTRL_OFS, 32'h00000000);
        rdchk(THRESH_OFS, 32'h00000032);
        rdchk(DELAY_OFS, 32'h000000c8);
        rdchk(INT_MASK_OFS, 32'h00000000);
        rdchk(8'h1c, 32'h00000000);
        check(b(err), 32'h00000001);
        // Settings beyond the range are clamped to its ends.
        apb(1'b1, THRESH_OFS, 32'hfffffda8);
        rdchk(THRESH_OFS, 32'hfffffe0c);
        apb(1'b1, DELAY_OFS, 32'h00004e20);
        rdchk(DELAY_OFS, 32'h00002710);
        apb(1'b1, DELAY_OFS, 32'h00000064);
        rdchk(DELAY_OFS, 32'h000000c8);
        apb(1'b1, THRESH_OFS, 32'h00000032);
        apb(1'b1, INT_MASK_OFS, 32'h0000000f);
        repeat (12 * PER) @(posedge pclk);
        check(b(general_start_out | general_trip_out | irq), 32'h0);
        rdchk(STATUS_OFS, 32'h0000001c);
        // Enabled: start after the filter, trip a delay after the fault.
        apb(1'b1, CTRL_OFS, 32'h00000001);
        wait_out(0, 1'b1, 2 * T100);
        check(near(waited, T100), 32'h1);
        wait_out(1, 1'b1, 2 * T100);
        check(near(waited, T100), 32'h1);
        check(b(irq), 32'h1);
        rdchk(INT_STAT_OFS, 32'h00000005);
        apb(1'b1, INT_MASK_OFS, 32'h00000000);
        @(posedge pclk);
        check(b(irq), 32'h0);
        apb(1'b1, INT_STAT_OFS, 32'h00000005);
        rdchk(INT_STAT_OFS, 32'h00000000);
        apb(1'b1, INT_MASK_OFS, 32'h0000000f);
        // Blocking drops both outputs with off events.
        block_in <= 1'b1;
        wait_out(0, 1'b0, 3);
        check(b(general_trip_out), 32'h0);
        rdchk(INT_STAT_OFS, 32'h0000000a);
        check(b(irq), 32'h1);
        apb(1'b1, INT_STAT_OFS, 32'h0000000a);
        block_in <= 1'b0;
        wait_out(0, 1'b1, 2 * T100);
        apb(1'b1, CTRL_OFS, 32'h00000003);
        repeat (3 * T100) @(posedge pclk);
        check(b(general_trip_out), 32'h0);
        // A negative setting picks up only on a falling frequency.
        apb(1'b1, THRESH_OFS, 32'hfffffe0c);
        wait_out(0, 1'b0, PER + 20);
        apb(1'b1, CTRL_OFS, 32'h00000001);
        step <= 8'shff;
        wait_out(0, 1'b1, 12 * PER);
        wait_out(1, 1'b1, T100 + 40);
        // Just under a tenth of rated voltage the element stops.
        volt <= VOLT_MIN - 16'h0001;
        wait_out(0, 1'b0, PER + 20);
        check(b(general_trip_out), 32'h0);
        // The comparator flag is only cleared at the next reading.
        sync(1);
        rdchk(STATUS_OFS, 32'h00000008);
        volt <= VOLT_MIN;
        wait_out(0, 1'b1, 8 * PER + T100);
        // A reset in mid-run clears outputs and settings.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(b(general_start_out | general_trip_out), 32'h0);
        presetn <= 1'b1;
        rdchk(CTRL_OFS, 32'h00000000);
        // Four invalid readings zero the frequency, four valid restore it.
        sync(5);
        apb(1'b0, FREQ_OFS, 32'h00000000);
        f0 = rd;
        valid <= 1'b0;
        sync(3);
        rdchk(FREQ_OFS, f0);
        sync(1);
        rdchk(FREQ_OFS, 32'h00000000);
        rdchk(STATUS_OFS, 32'h00000010);
        valid <= 1'b1;
        sync(3);
        rdchk(FREQ_OFS, 32'h00000000);
        sync(1);
        apb(1'b0, FREQ_OFS, 32'h00000000);
        check(b(|rd), 32'h1);
        finish_test();
    end
endmodule : rocof_protection_logic_bench
